// ---- hdl/cimc_core.sv ----
// mode flag, jump/exception mode handling and compact register mapping
`timescale 1ns/1ps
module cimc_core (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic compact_isa_enable_pin,
  input wire cimc_pkg::cimc_issue_t issue,
  input wire logic [31:0] pc,
  input wire logic [31:0] exception_return_address,
  input wire logic [31:0] error_return_address,
  input wire logic use_error_return,
  input wire logic exception_taken,
  input wire logic mode_64,
  input wire logic kernel_32,
  output logic mode_flag,
  output logic compact_enabled,
  output logic [31:0] saved_return_address,
  output cimc_pkg::cimc_result_t result,
  output logic [31:0] pc_next
);
  import cimc_pkg::*;

  logic pin_meta_reg, pin_sync_reg, pin_sync_next;
  logic en_reg, en_next;
  logic mode_reg, mode_next;
  logic ext_pend_reg, ext_pend_next;
  logic [10:0] ext_imm_reg, ext_imm_next;
  logic in_reset_reg, in_reset_next;
  logic [1:0] boot_cnt_reg, boot_cnt_next;
  logic [31:0] save_reg, save_next;
  cimc_result_t res_reg, res_next;
  logic [31:0] pcn_reg, pcn_next;

  // map 3-bit compact register code to a general register
  function automatic logic [4:0] map_reg(input logic [2:0] code);
    logic [4:0] r;
    r = {2'h0, code};
    if (code == 3'h0) begin
      r = CIMC_REG_S0;
    end else if (code == 3'h1) begin
      r = CIMC_REG_S1;
    end
    return r;
  endfunction

  // pin is asynchronous to the core, two flops before use
  always_comb begin
    pin_sync_next = pin_meta_reg;
  end

  // strap is latched over the first edges after reset, and during soft reset;
  // the wait lets both synchroniser stages fill before the pin is trusted
  always_comb begin
    in_reset_next = 1'b0;
    boot_cnt_next = boot_cnt_reg;
    en_next = en_reg;
    if (boot_cnt_reg != 2'h0) begin
      boot_cnt_next = boot_cnt_reg - 2'h1;
      in_reset_next = 1'b1;
    end
    if (in_reset_reg || soft_reset) begin
      en_next = pin_sync_reg;
    end
  end

  always_comb begin
    logic [31:0] ret_addr;
    logic [31:0] link;
    ret_addr = use_error_return ? error_return_address : exception_return_address;
    link = pc + (mode_reg ? CIMC_STEP_LONG : 32'h8);
    mode_next = mode_reg;
    save_next = save_reg;
    ext_pend_next = 1'b0;
    ext_imm_next = ext_imm_reg;
    pcn_next = pc + (mode_reg ? CIMC_STEP_SHORT : CIMC_STEP_LONG);
    res_next = '0;
    res_next.exc = CIMC_EXC_NONE;
    res_next.reg_a = map_reg(issue.rx);
    res_next.reg_b = map_reg(issue.ry);
    if (soft_reset) begin
      mode_next = CIMC_MODE_RESET;
      pcn_next = pc;
    end else if (exception_taken) begin
      save_next = {pc[31:1], mode_reg};
      mode_next = 1'b0;
      pcn_next = pc;
    end else if (issue.valid) begin
      if (ext_pend_reg) begin
        res_next.imm_ext = {ext_imm_reg[4:0], issue.imm};
        pcn_next = pc + CIMC_STEP_LONG;
      end
      unique case (issue.op)
        CIMC_OP_EXTEND: begin
          ext_pend_next = mode_reg;
          ext_imm_next = issue.imm;
          pcn_next = pc; // prefix completes with the next halfword
        end
        CIMC_OP_JAL: begin
          res_next.take_jump = 1'b1;
          res_next.target = issue.src;
          res_next.link_write = 1'b1;
          res_next.link_value = {link[31:1], mode_reg};
          res_next.reg_a = CIMC_REG_RA;
          if (mode_reg) begin
            pcn_next = pc + CIMC_STEP_LONG;
          end
        end
        CIMC_OP_JALX: begin
          if (!en_reg) begin
            res_next.exc = CIMC_EXC_RESERVED;
          end else begin
            mode_next = ~mode_reg;
            res_next.take_jump = 1'b1;
            res_next.target = issue.src;
            res_next.link_write = 1'b1;
            res_next.link_value = {link[31:1], mode_reg};
            res_next.reg_a = CIMC_REG_RA;
            if (mode_reg) begin
              pcn_next = pc + CIMC_STEP_LONG;
            end
          end
        end
        CIMC_OP_JR, CIMC_OP_JALR: begin
          if (!en_reg && issue.src[0]) begin
            res_next.exc = CIMC_EXC_ADDRESS;
          end else begin
            res_next.take_jump = 1'b1;
            res_next.target = {issue.src[31:1], 1'b0};
            if (en_reg) begin
              mode_next = issue.src[0];
            end
            if (issue.op == CIMC_OP_JALR) begin
              res_next.link_write = 1'b1;
              res_next.link_value = {link[31:1], mode_reg};
              res_next.reg_b = CIMC_REG_RA;
            end
          end
        end
        CIMC_OP_EXCEPTION_RETURN: begin
          if (!en_reg && ret_addr[0]) begin
            res_next.exc = CIMC_EXC_ADDRESS;
          end else begin
            res_next.take_jump = 1'b1;
            res_next.target = {ret_addr[31:1], 1'b0};
            if (en_reg) begin
              mode_next = ret_addr[0];
            end
          end
        end
        CIMC_OP_SYSCALL: res_next.exc = CIMC_EXC_SYSCALL;
        CIMC_OP_BREAK: res_next.exc = CIMC_EXC_BREAK;
        CIMC_OP_BRANCH_FLAG, CIMC_OP_CMP, CIMC_OP_CMPI, CIMC_OP_SLT, CIMC_OP_SLTI: begin
          res_next.flag_read = (issue.op == CIMC_OP_BRANCH_FLAG);
          res_next.flag_write = (issue.op != CIMC_OP_BRANCH_FLAG);
        end
        CIMC_OP_MOVE: res_next.reg_a = issue.r32;
        CIMC_OP_PC_REL: res_next.pc_operand = mode_reg;
        CIMC_OP_MULDIV: res_next.muldiv_dest = CIMC_ALU_HI | CIMC_ALU_LO;
        default: begin
        end
      endcase
      // extend on a class that refuses it is reserved
      if (ext_pend_reg && (issue.op inside {CIMC_OP_RR, CIMC_OP_CMP, CIMC_OP_SLT,
          CIMC_OP_MULDIV, CIMC_OP_JR, CIMC_OP_JALR, CIMC_OP_JAL, CIMC_OP_JALX,
          CIMC_OP_MOVE, CIMC_OP_EXTEND})) begin
        res_next.exc = CIMC_EXC_RESERVED;
        res_next.take_jump = 1'b0;
        mode_next = mode_reg;
      end
      if (issue.is_double && !mode_64 && !kernel_32) begin
        res_next.exc = CIMC_EXC_RESERVED;
        res_next.take_jump = 1'b0;
        mode_next = mode_reg; // a refused jump must not flip the mode
      end
      if (res_next.take_jump) begin
        pcn_next = res_next.target;
      end
    end
  end

  // register stage, every flop resets to a constant
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      en_reg <= 1'b0;
      in_reset_reg <= 1'b1;
      boot_cnt_reg <= CIMC_STRAP_SETTLE;
      mode_reg <= CIMC_MODE_RESET;
      ext_pend_reg <= 1'b0;
      ext_imm_reg <= 11'h000;
      save_reg <= 32'h0;
      res_reg <= '0;
      pcn_reg <= 32'h0;
    end else begin
      pin_meta_reg <= compact_isa_enable_pin;
      pin_sync_reg <= pin_sync_next;
      en_reg <= en_next;
      in_reset_reg <= in_reset_next;
      boot_cnt_reg <= boot_cnt_next;
      mode_reg <= mode_next;
      ext_pend_reg <= ext_pend_next;
      ext_imm_reg <= ext_imm_next;
      save_reg <= save_next;
      res_reg <= res_next;
      pcn_reg <= pcn_next;
    end
  end

  assign mode_flag = mode_reg;
  assign compact_enabled = en_reg;
  assign saved_return_address = save_reg;
  assign result = res_reg;
  assign pc_next = pcn_reg;

  property exc_clear_p;
    @(posedge core_clk) disable iff (!resetn)
      (exception_taken && !soft_reset) |=> (mode_reg == 1'b0 && save_reg[0] == $past(mode_reg));
  endproperty
  exc_clears_mode_a: assert property (exc_clear_p) else $error("exception mode save");

  soft_reset_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
      soft_reset |=> !mode_reg) else $error("soft reset kept mode");

  jalx_disabled_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue.valid && issue.op == CIMC_OP_JALX && !en_reg && !soft_reset && !exception_taken)
      |=> (result.exc == CIMC_EXC_RESERVED && !result.take_jump && $stable(mode_reg)))
      else $error("disabled exchange not refused");

  jr_odd_fault_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue.valid && issue.op == CIMC_OP_JR && !en_reg && issue.src[0] && !issue.is_double
      && !soft_reset && !exception_taken) |=> result.exc == CIMC_EXC_ADDRESS)
      else $error("odd jump target accepted");

  jump_target_even_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (result.take_jump && $past(issue.op) inside {CIMC_OP_JR, CIMC_OP_JALR, CIMC_OP_EXCEPTION_RETURN})
      |-> !result.target[0]) else $error("jump target odd");

  mode_change_cause_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (mode_reg != $past(mode_reg)) |-> ($past(soft_reset) || $past(exception_taken) ||
      ($past(issue.valid) && $past(issue.op) inside {CIMC_OP_JALX, CIMC_OP_JR,
      CIMC_OP_JALR, CIMC_OP_EXCEPTION_RETURN}))) else $error("mode changed without cause");

  disabled_mode_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (!en_reg && !mode_reg) |=> !mode_reg) else $error("mode set while disabled");

  // result is registered from the mode seen in the issue cycle, one edge back
  link_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
      result.link_write |-> result.link_value[0] == $past(mode_reg))
      else $error("link bit lost mode");

  // instruction that no reset, exception, prefix or privilege check overrides
  logic plain_issue;
  assign plain_issue = issue.valid && !soft_reset && !exception_taken && !issue.is_double
      && !ext_pend_reg;

  jalx_invert_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_JALX && en_reg)
      |=> (mode_reg != $past(mode_reg) && result.take_jump))
      else $error("exchange kept mode");

  jal_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_JAL) |=> $stable(mode_reg))
      else $error("plain call changed mode");

  regjump_mode_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op inside {CIMC_OP_JR, CIMC_OP_JALR} && en_reg)
      |=> (mode_reg == $past(issue.src[0]) && result.exc == CIMC_EXC_NONE))
      else $error("register jump mode wrong");

  exception_return_restore_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_EXCEPTION_RETURN && en_reg)
      |=> (mode_reg == $past(use_error_return ? error_return_address[0] :
      exception_return_address[0]))) else $error("return did not restore mode");

  exception_return_odd_fault_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_EXCEPTION_RETURN && !en_reg && (use_error_return ?
      error_return_address[0] : exception_return_address[0]))
      |=> result.exc == CIMC_EXC_ADDRESS) else $error("odd return accepted");

  ext_refused_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue.valid && ext_pend_reg && issue.op == CIMC_OP_RR && !soft_reset && !exception_taken)
      |=> result.exc == CIMC_EXC_RESERVED) else $error("prefix accepted on register op");

  double_refused_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (issue.valid && issue.is_double && !mode_64 && !kernel_32 && !soft_reset
      && !exception_taken) |=> (result.exc == CIMC_EXC_RESERVED && !result.take_jump
      && $stable(mode_reg))) else $error("doubleword op accepted");

  map_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_RR) |=> result.reg_a == (($past(issue.rx) < 3'h2) ?
      {4'h8, $past(issue.rx[0])} : {2'h0, $past(issue.rx)})) else $error("register map wrong");

  trap_exc_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op == CIMC_OP_SYSCALL) |=> result.exc == CIMC_EXC_SYSCALL)
      else $error("system call not raised");

  strap_latch_a: assert property (@(posedge core_clk) disable iff (!resetn)
      soft_reset |=> compact_enabled == $past(pin_sync_reg)) else $error("strap not resampled");

  pc_step_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && mode_reg && issue.op == CIMC_OP_RR)
      |=> pc_next == $past(pc) + CIMC_STEP_SHORT) else $error("compact pc step wrong");

  flag_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (plain_issue && issue.op inside {CIMC_OP_CMP, CIMC_OP_CMPI, CIMC_OP_SLT, CIMC_OP_SLTI})
      |=> result.flag_write) else $error("flag register not written");
endmodule

// ---- common/cimc_pkg.sv ----
// package for the compact isa mode control block
// Operation
// - enable pin sampled at reset gates mode changes
// - mode flag selects 32-bit or compact decode
// - 3-bit field maps to registers 16,17,2-7
// - implicit registers 24 flag, 29 sp, 31 return
// - flag branches, compares, set-less-than use register 24
// - only moves reach all 32 registers
// - multiply/divide upper to high, lower to low
// - pc operand only for pc-relative add/load
// - mode changes only by jumps, exceptions, reset
// - jump-link-exchange inverts mode, jump-link keeps it
// - enabled register jumps take mode from bit 0
// - linking jumps store mode in return bit 0
// - exception saves mode to bit 0, clears flag
// - cold or soft reset clears mode flag
// - enabled exception return restores mode from bit 0
// - disabled exchange jump raises reserved-instruction
// - disabled register jump odd target raises address error
// - disabled exception return odd address raises address error
// - extend prefix widens the next immediate only
// - only listed classes accept extend prefix
// - doubleword ops need 64-bit or kernel mode
// - system call and breakpoint raise exceptions
package cimc_pkg;
  localparam logic [4:0] CIMC_REG_FLAG = 5'h18;
  localparam logic [4:0] CIMC_REG_SP = 5'h1d;
  localparam logic [4:0] CIMC_REG_RA = 5'h1f;
  localparam logic [4:0] CIMC_REG_S0 = 5'h10;
  localparam logic [4:0] CIMC_REG_S1 = 5'h11;
  localparam logic CIMC_MODE_RESET = 1'b0;
  localparam logic [1:0] CIMC_STRAP_SETTLE = 2'h2;
  localparam logic [31:0] CIMC_STEP_SHORT = 32'h2;
  localparam logic [31:0] CIMC_STEP_LONG = 32'h4;
  localparam logic [1:0] CIMC_ALU_HI = 2'h1;
  localparam logic [1:0] CIMC_ALU_LO = 2'h2;

  // instruction class handed in by the decoder
  typedef enum logic [4:0] {
    CIMC_OP_NONE, CIMC_OP_JAL, CIMC_OP_JALX, CIMC_OP_JR, CIMC_OP_JALR, CIMC_OP_EXCEPTION_RETURN,
    CIMC_OP_EXTEND, CIMC_OP_LOADSTORE, CIMC_OP_ALU_IMM, CIMC_OP_CMPI, CIMC_OP_BRANCH,
    CIMC_OP_BRANCH_FLAG, CIMC_OP_SHIFT_IMM, CIMC_OP_RR, CIMC_OP_CMP, CIMC_OP_SLT,
    CIMC_OP_SLTI, CIMC_OP_MULDIV, CIMC_OP_MOVE, CIMC_OP_PC_REL, CIMC_OP_SYSCALL,
    CIMC_OP_BREAK
  } cimc_op_t;

  typedef enum logic [2:0] {
    CIMC_EXC_NONE, CIMC_EXC_RESERVED, CIMC_EXC_ADDRESS, CIMC_EXC_SYSCALL, CIMC_EXC_BREAK
  } cimc_exc_t;

  // one issued instruction
  typedef struct packed {
    logic valid;
    cimc_op_t op;
    logic is_double;
    logic [2:0] rx;
    logic [2:0] ry;
    logic [4:0] r32;
    logic [31:0] src;
    logic [10:0] imm;
  } cimc_issue_t;

  // resolved control results
  typedef struct packed {
    logic take_jump;
    logic [31:0] target;
    logic [31:0] link_value;
    logic link_write;
    cimc_exc_t exc;
    logic [4:0] reg_a;
    logic [4:0] reg_b;
    logic flag_read;
    logic flag_write;
    logic pc_operand;
    logic [15:0] imm_ext;
    logic [1:0] muldiv_dest;
  } cimc_result_t;
endpackage

// ---- testbench/cimc_tb.sv ----
// self-checking bench for the compact isa mode control core
`timescale 1ns/1ps
module testbench;
  import cimc_pkg::*;
  logic core_clk, resetn, soft_reset, compact_isa_enable_pin, use_error_return;
  logic exception_taken, mode_64, kernel_32, mode_flag, compact_enabled;
  logic [31:0] pc, exception_return_address, error_return_address, saved_return_address, pc_next;
  cimc_issue_t issue;
  cimc_result_t result;
  int fail_count, compares;

  cimc_core u_dut (
    .core_clk(core_clk), .resetn(resetn), .soft_reset(soft_reset),
    .compact_isa_enable_pin(compact_isa_enable_pin), .issue(issue), .pc(pc),
    .exception_return_address(exception_return_address),
    .error_return_address(error_return_address), .use_error_return(use_error_return),
    .exception_taken(exception_taken), .mode_64(mode_64), .kernel_32(kernel_32),
    .mode_flag(mode_flag), .compact_enabled(compact_enabled),
    .saved_return_address(saved_return_address), .result(result), .pc_next(pc_next)
  );

  // 20 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // issue is never cleared here, so back-to-back calls assign it once per step
  task automatic go(cimc_op_t op, logic [31:0] src = 32'h0, logic [2:0] rx = 3'h0,
                    logic [10:0] imm = 11'h0, logic dbl = 1'b0);
    issue = '{1'b1, op, dbl, rx, 3'h0, 5'h0, src, imm};
    @(posedge core_clk);
    #1;
  endtask

  task automatic idle(int n);
    issue = '0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic t_jumps();
    go(CIMC_OP_JR, 32'h1001);
    check("jr jump", result.take_jump, 1'b1);
    check("jr target", result.target, 32'h1000);
    check("jr exc", result.exc, CIMC_EXC_NONE);
    check("jr mode", mode_flag, 1'b1);
    check("jr pc next", pc_next, 32'h1000);
    go(CIMC_OP_JAL);
    check("jal mode", mode_flag, 1'b1);
    check("jal link", result.link_value, 32'h105);
    check("jal write", result.link_write, 1'b1);
    check("jal ra", result.reg_a, 32'h1f);
    go(CIMC_OP_JALX);
    check("jalx mode", mode_flag, 1'b0);
    check("jalx link", result.link_value, 32'h105);
    go(CIMC_OP_JALR, 32'h2000);
    check("jalr mode", mode_flag, 1'b0);
    check("jalr target", result.target, 32'h2000);
    check("jalr link", result.link_value, 32'h108);
    check("jalr ra", result.reg_b, 32'h1f);
  endtask

  task automatic t_compact();
    cimc_op_t wr[4];
    wr = '{CIMC_OP_CMP, CIMC_OP_CMPI, CIMC_OP_SLT, CIMC_OP_SLTI};
    go(CIMC_OP_JR, 32'h1001);
    for (int i = 0; i < 8; i++) begin
      go(CIMC_OP_RR, 32'h0, 3'(i));
      check("mapped reg", result.reg_a, (i < 2) ? 16 + i : i);
      check("pc step", pc_next, 32'h102);
    end
    go(CIMC_OP_BRANCH_FLAG);
    check("flag read", result.flag_read, 1'b1);
    foreach (wr[i]) begin
      go(wr[i]);
      check("flag write", result.flag_write, 1'b1);
    end
    go(CIMC_OP_MULDIV);
    check("muldiv dest", result.muldiv_dest, 2'h3);
    go(CIMC_OP_PC_REL);
    check("pc operand", result.pc_operand, 1'b1);
    check("mode kept", mode_flag, 1'b1);
    go(CIMC_OP_MOVE);
    check("move reg", result.reg_a, 32'h0);
    go(CIMC_OP_SYSCALL);
    check("syscall", result.exc, CIMC_EXC_SYSCALL);
    go(CIMC_OP_BREAK);
    check("break", result.exc, CIMC_EXC_BREAK);
    go(CIMC_OP_EXTEND, 32'h0, 3'h0, 11'h01f);
    check("prefix pc", pc_next, 32'h100);
    go(CIMC_OP_ALU_IMM, 32'h0, 3'h0, 11'h7ff);
    check("ext imm", result.imm_ext, 16'hffff);
    check("ext pc", pc_next, 32'h104);
    go(CIMC_OP_EXTEND);
    go(CIMC_OP_RR);
    check("bad extend", result.exc, CIMC_EXC_RESERVED);
    go(CIMC_OP_LOADSTORE, 32'h0, 3'h0, 11'h0, 1'b1);
    check("double user", result.exc, CIMC_EXC_RESERVED);
    kernel_32 = 1'b1;
    go(CIMC_OP_LOADSTORE, 32'h0, 3'h0, 11'h0, 1'b1);
    check("double kernel", result.exc, CIMC_EXC_NONE);
    kernel_32 = 1'b0;
    mode_64 = 1'b1;
    go(CIMC_OP_LOADSTORE, 32'h0, 3'h0, 11'h0, 1'b1);
    check("double 64", result.exc, CIMC_EXC_NONE);
    mode_64 = 1'b0;
  endtask

  // exception entry and return, starting in compact mode
  task automatic t_exc();
    exception_taken = 1'b1;
    idle(1);
    exception_taken = 1'b0;
    check("exc mode", mode_flag, 1'b0);
    check("exc saved", saved_return_address, 32'h101);
    exception_return_address = 32'h3001;
    go(CIMC_OP_EXCEPTION_RETURN);
    check("exception_return mode", mode_flag, 1'b1);
    check("exception_return target", result.target, 32'h3000);
    use_error_return = 1'b1;
    go(CIMC_OP_EXCEPTION_RETURN);
    check("err mode", mode_flag, 1'b0);
    check("err target", result.target, 32'h4000);
    use_error_return = 1'b0;
  endtask

  // strap low, soft reset, then the refusals of disabled mode
  task automatic t_disabled();
    go(CIMC_OP_JR, 32'h1001);
    compact_isa_enable_pin = 1'b0;
    idle(3);
    soft_reset = 1'b1;
    idle(2);
    soft_reset = 1'b0;
    idle(1);
    check("strap off", compact_enabled, 1'b0);
    check("soft reset mode", mode_flag, 1'b0);
    go(CIMC_OP_JALX);
    check("jalx refused", result.exc, CIMC_EXC_RESERVED);
    check("jalx no jump", result.take_jump, 1'b0);
    go(CIMC_OP_JR, 32'h1001);
    check("jr odd", result.exc, CIMC_EXC_ADDRESS);
    check("jr odd mode", mode_flag, 1'b0);
    go(CIMC_OP_JALR, 32'h1000);
    check("jalr even", result.exc, CIMC_EXC_NONE);
    go(CIMC_OP_EXCEPTION_RETURN);
    check("exception_return odd", result.exc, CIMC_EXC_ADDRESS);
  endtask

  initial begin
    resetn = 1'b0;
    soft_reset = 1'b0;
    compact_isa_enable_pin = 1'b1;
    use_error_return = 1'b0;
    exception_taken = 1'b0;
    mode_64 = 1'b0;
    kernel_32 = 1'b0;
    pc = 32'h100;
    exception_return_address = 32'h0;
    error_return_address = 32'h4000;
    issue = '0;
    fail_count = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    idle(4);
    check("reset mode", mode_flag, 1'b0);
    check("strap on", compact_enabled, 1'b1);
    t_jumps();
    t_compact();
    t_exc();
    t_disabled();
    final_report();
  end
endmodule
